// *** design/vfd_decoder_params.svh ***
// Constants for the character display instruction decoder
`ifndef VFD_DECODER_PARAMS_SVH
`define VFD_DECODER_PARAMS_SVH
`define ADDR_CTRL 6'h00
`define ADDR_CMD 6'h04
`define ADDR_STATUS 6'h08
`define ADDR_RDATA 6'h0C
`define ADDR_CELL 6'h10
`define ADDR_GLYPH 6'h14
`define CHAR_DEPTH 128
`define GLYPH_DEPTH 64
`define SPACE_CODE 8'h20
`define HOME_ADDR 7'h00
`define ROW0_LAST 7'h27
`define ROW1_FIRST 7'h40
`define ROW1_LAST 7'h67
`define GLYPH_LAST 7'h3F
`define PAN_LAST 6'h27
`define BLINK_HALF_S_MS 500
`define CLK_MHZ 100
`define BLINK_HALF_CYC (`BLINK_HALF_S_MS * 1000 * `CLK_MHZ)
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// *** design/vfd_decoder_pkg.sv ***
// Types for the character display instruction decoder
package vfd_decoder_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_CLEAR = 2'b11
	} exec_state_t;
	typedef struct packed {
		logic step_direction;
		logic auto_pan_enable;
		logic panel_visible;
		logic underline_on;
		logic flicker_on;
		logic bus_width_sel;
		logic two_row_sel;
		logic [1:0] luma_level;
	} disp_cfg_t;
	typedef struct packed {
		logic instr_data_select;
		logic is_read;
		logic [7:0] data;
	} cmd_t;
endpackage

// *** design/vfd_char_display_instr_decoder.sv ***
// Instruction decoder and executor of a two-line character display controller
// Overview of operation
// - Clear fills character memory with spaces, homes pointer, unshifts, sets increment.
// - Home loads pointer 00H into character memory and unshifts; memories untouched.
// - Entry mode sets step direction and auto-pan; 0 decrements, 1 increments.
// - Auto-pan shifts window on character writes only: right if decrementing, else left.
// - Display control latches visible, underline, flicker; visible 0 blanks the panel.
// - Underline on draws cursor as eighth pixel row at the pointer position.
// - Flicker on alternates cursor character with all-on pattern near 1Hz, 50%.
// - Shift instruction steps pointer by direction bit, from 00H if glyph memory was targeted; pan bit also shifts window.
// - After a shift instruction the pointer targets character memory.
// - Function set: bus width 0 means 4-bit bus, 1 means 8-bit bus.
// - Row select 0 gives one line, 1 gives two lines.
// - Luma level 00,01,10,11 gives 100,75,50,25 percent brightness.
// - Glyph address set loads 6-bit pointer and targets glyph memory.
// - Character address set loads 7-bit pointer and targets character memory.
// - Instruction read returns pointer on bits 6..0, busy flag 0 on bit 7.
// - Command writes stall while the executor runs or clears; bit 7 busy flag is always 0.
// - Setting instructions leave memories alone; clear, home, shift and address sets touch the pointer.
// - Character pointer wraps 27H/40H and 67H/00H; glyph pointer wraps 3FH/00H.
// - Data access uses selected memory at pointer, then steps; character writes also auto-pan.
// - Reset: spaces, pointer and shift cleared, increment, all off, 8-bit, two lines, full.
// - Select low marks an instruction, high marks data.
`timescale 1ns/1ps
`include "vfd_decoder_params.svh"
module vfd_char_display_instr_decoder
	import vfd_decoder_pkg::*;
#(
	parameter int BLINK_HALF = `BLINK_HALF_CYC
) (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [8:0] CFG_OUT,
	output logic [5:0] PAN_OFFSET,
	output logic BLINK_PHASE
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] char_code_memory [`CHAR_DEPTH];
	logic [7:0] glyph_pattern_memory [`GLYPH_DEPTH];
	logic [6:0] cursor_pointer;
	logic glyph_sel;
	logic [5:0] pan;
	disp_cfg_t cfg;
	exec_state_t state;
	cmd_t cmd;
	logic [6:0] clr_idx;
	logic [7:0] rdata_byte;
	logic aw_hold, w_hold;
	logic [5:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] blink_cnt;
	logic blink;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic [6:0] step_char(input logic [6:0] p, input logic up);
		logic [6:0] r;
		r = up ? p + 7'h01 : p - 7'h01;
		if (up && p == `ROW0_LAST) r = `ROW1_FIRST;
		if (up && p == `ROW1_LAST) r = `HOME_ADDR;
		if (!up && p == `ROW1_FIRST) r = `ROW0_LAST;
		if (!up && p == `HOME_ADDR) r = `ROW1_LAST;
		return r;
	endfunction

	function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic up, input logic g);
		logic [6:0] r;
		r = g ? ((up ? p + 7'h01 : p - 7'h01) & `GLYPH_LAST) : step_char(p, up);
		return r;
	endfunction

	function automatic logic [5:0] step_pan(input logic [5:0] s, input logic left);
		logic [5:0] r;
		if (left) r = (s == `PAN_LAST) ? 6'h00 : s + 6'h01;
		else r = (s == 6'h00) ? `PAN_LAST : s - 6'h01;
		return r;
	endfunction

	wire wr_go = aw_hold && w_hold && !S_AXI_BVALID;
	wire wr_cmd = wr_go && aw_addr == `ADDR_CMD && w_strb[0] && state == ST_IDLE;
	wire wr_ok = aw_addr == `ADDR_CMD || aw_addr == `ADDR_CTRL;
	wire wr_done = wr_go && (state == ST_IDLE || aw_addr != `ADDR_CMD);
	wire next_aw_hold = !wr_done && (aw_hold || (S_AXI_AWVALID && S_AXI_AWREADY));
	wire next_w_hold = !wr_done && (w_hold || (S_AXI_WVALID && S_AXI_WREADY));
	wire next_bvalid = wr_done || (S_AXI_BVALID && !S_AXI_BREADY);

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 6'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `RESP_OKAY;
		end else begin
			aw_hold <= next_aw_hold;
			w_hold <= next_w_hold;
			S_AXI_BVALID <= next_bvalid;
			// Ready comes from the next hold state, so a taken slot is never offered again
			S_AXI_AWREADY <= !next_aw_hold && !next_bvalid;
			S_AXI_WREADY <= !next_w_hold && !next_bvalid;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_addr <= S_AXI_AWADDR[5:0];
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (wr_done) begin
				S_AXI_BRESP <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------------------------------
	// Command capture: a write to the command word is one bus transfer
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			cmd <= '0;
		end else if (wr_cmd) begin
			cmd <= cmd_t'(w_data[9:0]);
		end
	end

	// ----------------------------------------------------------------
	// Executor
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state <= ST_CLEAR;
			clr_idx <= 7'h00;
			cursor_pointer <= `HOME_ADDR;
			glyph_sel <= 1'b0;
			pan <= 6'h00;
			cfg <= '{step_direction: 1'b1, auto_pan_enable: 1'b0, panel_visible: 1'b0,
				underline_on: 1'b0, flicker_on: 1'b0, bus_width_sel: 1'b1,
				two_row_sel: 1'b1, luma_level: 2'b00};
			rdata_byte <= 8'h00;
		end else begin
			case (state)
			ST_IDLE: begin
				if (wr_cmd) state <= ST_EXEC;
			end
			ST_EXEC: begin
				state <= ST_IDLE;
				if (cmd.instr_data_select) begin
					if (cmd.is_read)
						rdata_byte <= glyph_sel ? glyph_pattern_memory[cursor_pointer[5:0]]
							: char_code_memory[cursor_pointer];
					cursor_pointer <= step_ptr(cursor_pointer, cfg.step_direction, glyph_sel);
					if (!cmd.is_read && !glyph_sel && cfg.auto_pan_enable)
						pan <= step_pan(pan, cfg.step_direction);
				end else if (cmd.is_read) begin
					rdata_byte <= {1'b0, cursor_pointer};
				end else if (cmd.data[7]) begin
					cursor_pointer <= cmd.data[6:0];
					glyph_sel <= 1'b0;
				end else if (cmd.data[6]) begin
					cursor_pointer <= {1'b0, cmd.data[5:0]};
					glyph_sel <= 1'b1;
				end else if (cmd.data[5]) begin
					cfg.bus_width_sel <= cmd.data[4];
					cfg.two_row_sel <= cmd.data[3];
					cfg.luma_level <= cmd.data[1:0];
				end else if (cmd.data[4]) begin
					cursor_pointer <= step_char(glyph_sel ? `HOME_ADDR : cursor_pointer, cmd.data[2]);
					glyph_sel <= 1'b0;
					if (cmd.data[3]) pan <= step_pan(pan, !cmd.data[2]);
				end else if (cmd.data[3]) begin
					cfg.panel_visible <= cmd.data[2];
					cfg.underline_on <= cmd.data[1];
					cfg.flicker_on <= cmd.data[0];
				end else if (cmd.data[2]) begin
					cfg.step_direction <= cmd.data[1];
					cfg.auto_pan_enable <= cmd.data[0];
				end else if (cmd.data[1]) begin
					cursor_pointer <= `HOME_ADDR;
					glyph_sel <= 1'b0;
					pan <= 6'h00;
				end else if (cmd.data[0]) begin
					cursor_pointer <= `HOME_ADDR;
					glyph_sel <= 1'b0;
					pan <= 6'h00;
					cfg.step_direction <= 1'b1;
					clr_idx <= 7'h00;
					state <= ST_CLEAR;
				end
			end
			ST_CLEAR: begin
				clr_idx <= clr_idx + 7'h01;
				if (clr_idx == 7'h7F) state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Memories, one flop row per entry
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `CHAR_DEPTH; gi++) begin : g_char
			always_ff @(posedge CORE_CLK or negedge RST_B) begin
				if (!RST_B)
					char_code_memory[gi] <= `SPACE_CODE;
				else if (state == ST_CLEAR && clr_idx == 7'(gi))
					char_code_memory[gi] <= `SPACE_CODE;
				else if (state == ST_EXEC && cmd.instr_data_select && !cmd.is_read && !glyph_sel
					&& cursor_pointer == 7'(gi))
					char_code_memory[gi] <= cmd.data;
			end
		end
		for (gi = 0; gi < `GLYPH_DEPTH; gi++) begin : g_glyph
			always_ff @(posedge CORE_CLK or negedge RST_B) begin
				if (!RST_B)
					glyph_pattern_memory[gi] <= 8'h00;
				else if (state == ST_EXEC && cmd.instr_data_select && !cmd.is_read && glyph_sel
					&& cursor_pointer[5:0] == 6'(gi))
					glyph_pattern_memory[gi] <= cmd.data;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Blink divider
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			blink_cnt <= 32'h0;
			blink <= 1'b0;
		end else if (blink_cnt == 32'(BLINK_HALF - 1)) begin
			blink_cnt <= 32'h0;
			blink <= !blink;
		end else begin
			blink_cnt <= blink_cnt + 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// Read channel and registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			S_AXI_RRESP <= `RESP_OKAY;
			CFG_OUT <= 9'h0;
			PAN_OFFSET <= 6'h00;
			BLINK_PHASE <= 1'b0;
		end else begin
			CFG_OUT <= cfg;
			PAN_OFFSET <= pan;
			BLINK_PHASE <= cfg.flicker_on & blink;
			S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
			if (S_AXI_ARREADY && S_AXI_ARVALID) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP <= `RESP_OKAY;
				case (S_AXI_ARADDR[5:0])
				`ADDR_CTRL: S_AXI_RDATA <= {23'h0, cfg};
				`ADDR_CMD: S_AXI_RDATA <= {22'h0, cmd};
				`ADDR_STATUS: S_AXI_RDATA <= {22'h0, state != ST_IDLE, glyph_sel, 1'b0, cursor_pointer};
				`ADDR_RDATA: S_AXI_RDATA <= {24'h0, rdata_byte};
				`ADDR_CELL: S_AXI_RDATA <= {24'h0, char_code_memory[cursor_pointer]};
				`ADDR_GLYPH: S_AXI_RDATA <= {18'h0, pan, glyph_pattern_memory[cursor_pointer[5:0]]};
				default: begin
					S_AXI_RDATA <= 32'h0;
					S_AXI_RRESP <= `RESP_SLVERR;
				end
				endcase
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end
endmodule

// *** sim/vfd_decoder_assertions.sv ***
// Checker for the instruction decoder ports
`timescale 1ns/1ps
module vfd_decoder_assertions #(
	parameter int BLINK_HALF = 4
) (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [8:0] CFG_OUT,
	input wire logic [5:0] PAN_OFFSET,
	input wire logic BLINK_PHASE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	logic [5:0] ar_addr;
	int hi_cnt;
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) ar_addr <= 6'h00;
		else if (S_AXI_ARVALID && S_AXI_ARREADY) ar_addr <= S_AXI_ARADDR[5:0];
	end
	// Length of the current high phase of the blink output
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) hi_cnt <= 0;
		else if (BLINK_PHASE) hi_cnt <= hi_cnt + 1;
		else hi_cnt <= 0;
	end
	chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	chk_rvalid_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read answer dropped");
	chk_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write answer dropped");
	chk_busy_zero: assert property (S_AXI_RVALID && ar_addr == 6'h08 |-> !S_AXI_RDATA[7])
		else $error("busy flag set");
	chk_pan_step: assert property ($changed(PAN_OFFSET) |-> PAN_OFFSET == 6'h00 || PAN_OFFSET == 6'h27
		|| PAN_OFFSET - $past(PAN_OFFSET) == 6'h01 || $past(PAN_OFFSET) - PAN_OFFSET == 6'h01)
		else $error("window moved more than one");
	chk_pan_range: assert property (PAN_OFFSET <= 6'h27)
		else $error("window offset out of range");
	chk_blink_off: assert property (!CFG_OUT[4] ##1 !CFG_OUT[4] |-> !$past(BLINK_PHASE))
		else $error("blink while disabled");
	chk_blink_len: assert property (BLINK_PHASE |-> hi_cnt < BLINK_HALF)
		else $error("blink phase too long");
	cov_blink: cover property ($rose(BLINK_PHASE));
	cov_pan: cover property ($changed(PAN_OFFSET));
	cov_status: cover property (S_AXI_RVALID && ar_addr == 6'h08);
endmodule
bind vfd_char_display_instr_decoder vfd_decoder_assertions #(.BLINK_HALF(BLINK_HALF)) i_chk (
	.CORE_CLK(CORE_CLK), .RST_B(RST_B), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY), .CFG_OUT(CFG_OUT), .PAN_OFFSET(PAN_OFFSET), .BLINK_PHASE(BLINK_PHASE));

// *** sim/vfd_host.sv ***
// Host model issuing register transfers
`timescale 1ns/1ps
module vfd_host (
	input wire logic clk,
	output logic [31:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [31:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
		wstrb = 4'hF;
	end
	// Back to back, no busy polling; select bit sent with every byte
	task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
		bit ad;
		bit wd;
		ad = 0;
		wd = 0;
		@(posedge clk);
		awaddr <= {26'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Ready flags are flop outputs, settled at the falling edge before the taking edge
		while (!(ad && wd)) begin
			@(negedge clk);
			if (awready === 1'b1) ad = 1;
			if (wready === 1'b1) wd = 1;
			@(posedge clk);
			if (ad) awvalid <= 1'b0;
			if (wd) wvalid <= 1'b0;
		end
		do @(negedge clk); while (bvalid !== 1'b1);
		r = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge clk);
		araddr <= {26'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge clk); while (arready !== 1'b1);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (rvalid !== 1'b1);
		d = rdata;
		@(posedge clk);
		rready <= 1'b0;
	endtask
endmodule

// *** sim/vfd_char_display_instr_decoder_tb.sv ***
// Self-checking testbench for the instruction decoder
`timescale 1ns/1ps
module vfd_char_display_instr_decoder_tb;
	import vfd_decoder_pkg::*;
	logic core_clk = 0;
	logic rst_b = 0;
	logic [31:0] awaddr, wdata, araddr, rdata, v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, blink_phase;
	logic [8:0] cfg_out;
	logic [5:0] pan_offset;
	int fail_count = 0;
	int checked = 0;
	always #5 core_clk = ~core_clk;
	vfd_char_display_instr_decoder #(.BLINK_HALF(4)) i_vfd_char_display_instr_decoder (
		.CORE_CLK(core_clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CFG_OUT(cfg_out),
		.PAN_OFFSET(pan_offset), .BLINK_PHASE(blink_phase));
	vfd_host i_vfd_host (.clk(core_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rvalid(rvalid), .rready(rready));
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_sim;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task cmd(input logic s, input logic rd, input logic [7:0] b);
		i_vfd_host.wr(6'h04, {22'h0, s, rd, b}, r);
	endtask
	// Status once the block is idle
	task st;
		do i_vfd_host.rd(6'h08, v); while (v[9] !== 1'b0);
	endtask
	task t_reset;
		st;
		chk("status", v, 32'h0);
		chk("cfg", 32'(cfg_out), 32'h10C);
		i_vfd_host.rd(6'h10, v);
		chk("cell", v, 32'h20);
	endtask
	task t_wrap;
		cmd(0, 0, 8'hA7);
		cmd(1, 0, 8'h41);
		st;
		chk("ptr", v, 32'h40);
		cmd(0, 0, 8'hA7);
		cmd(1, 1, 8'h00);
		i_vfd_host.rd(6'h0C, v);
		chk("rdata", v, 32'h41);
	endtask
	task t_pan;
		cmd(0, 0, 8'h05);
		cmd(0, 0, 8'h80);
		cmd(1, 0, 8'h55);
		st;
		chk("ptr", v, 32'h67);
		chk("pan", 32'(pan_offset), 32'h27);
		cmd(1, 1, 8'h00);
		st;
		chk("pan", 32'(pan_offset), 32'h27);
		cmd(0, 0, 8'h1C);
		st;
		chk("ptr", v, 32'h67);
		chk("pan", 32'(pan_offset), 32'h26);
	endtask
	task t_glyph;
		cmd(0, 0, 8'h06);
		cmd(0, 0, 8'h7F);
		cmd(1, 0, 8'h1F);
		st;
		chk("ptr", v, 32'h100);
		chk("pan", 32'(pan_offset), 32'h26);
		cmd(0, 0, 8'h7F);
		i_vfd_host.rd(6'h14, v);
		chk("glyph", v, 32'h261F);
		cmd(0, 0, 8'h10);
		st;
		chk("ptr", v, 32'h67);
	endtask
	task t_cfg;
		for (int i = 0; i < 4; i++) begin
			cmd(0, 0, {3'b001, i[0], i[1], 1'b0, i[1:0]});
			st;
			chk("cfg", 32'(cfg_out[3:0]), {28'h0, i[0], i[1], i[1:0]});
		end
		cmd(0, 0, 8'h0F);
		v = 0;
		repeat (20) begin
			@(negedge core_clk);
			v[0] = v[0] | blink_phase;
		end
		chk("cfg", 32'(cfg_out), 32'h17F);
		chk("blink", v, 32'h1);
		cmd(0, 1, 8'h00);
		i_vfd_host.rd(6'h0C, v);
		chk("ptr", v, 32'h67);
	endtask
	task t_clear;
		cmd(0, 0, 8'h04);
		cmd(0, 0, 8'h01);
		st;
		chk("ptr", v, 32'h0);
		chk("pan", 32'(pan_offset), 32'h0);
		chk("dir", 32'(cfg_out[8]), 32'h1);
		i_vfd_host.rd(6'h10, v);
		chk("cell", v, 32'h20);
		cmd(0, 0, 8'h1C);
		cmd(0, 0, 8'h03);
		st;
		chk("ptr", v, 32'h0);
		chk("pan", 32'(pan_offset), 32'h0);
		i_vfd_host.wr(6'h20, 32'h0, r);
		chk("resp", 32'(r), 32'h2);
		i_vfd_host.rd(6'h20, v);
		chk("rdata", v, 32'h0);
		chk("rresp", 32'(rresp), 32'h2);
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		t_reset;
		t_wrap;
		t_pan;
		t_glyph;
		t_cfg;
		t_clear;
		end_sim;
	end
	initial begin
		#100us;
		fail_count++;
		end_sim;
	end
endmodule
